// >>> verilog/tcp_pkg.sv
package tcp_pkg;

    // Register byte addresses on the AXI4-Lite bus
    localparam logic [7:0] OFS_INT_CTRL     = 8'h00;
    localparam logic [7:0] OFS_PER_FLAGS    = 8'h04;
    localparam logic [7:0] OFS_PER_MASK     = 8'h08;
    localparam logic [7:0] OFS_WIDE_CTRL    = 8'h0c;
    localparam logic [7:0] OFS_WIDE_COUNT   = 8'h10;
    localparam logic [7:0] OFS_NARROW_CTRL  = 8'h14;
    localparam logic [7:0] OFS_NARROW_COUNT = 8'h18;
    localparam logic [7:0] OFS_NARROW_PER   = 8'h1c;
    localparam logic [7:0] OFS_CCP_CTRL     = 8'h20;
    localparam logic [7:0] OFS_CCP_DATA     = 8'h24;

    // Reset values and writable-bit masks
    localparam logic [7:0]  RST_BYTE        = 8'h00;
    localparam logic [15:0] RST_WORD        = 16'h0000;
    localparam logic [7:0]  WMASK_INT_CTRL  = 8'h7f;
    localparam logic [7:0]  WMASK_FLAGS     = 8'h0f;
    localparam logic [7:0]  WMASK_WIDE_CTRL = 8'h3f;
    localparam logic [7:0]  WMASK_NAR_CTRL  = 8'h7f;
    localparam logic [7:0]  WMASK_CCP_CTRL  = 8'h3f;

    // Interrupt control fields
    localparam int IC_PORT_CHG   = 0;
    localparam int IC_PORT_EDGE  = 1;
    localparam int IC_FR_OVF     = 2;
    localparam int IC_EN_LO      = 3;
    localparam int IC_PERIPH_EN  = 6;

    // Peripheral flag / mask fields
    localparam int PF_WIDE   = 0;
    localparam int PF_NARROW = 1;
    localparam int PF_CCP    = 2;
    localparam int PF_SERIAL = 3;

    // Wide timer control fields
    localparam int WT_ON     = 0;
    localparam int WT_EXT    = 1;
    localparam int WT_SYNC   = 2;
    localparam int WT_PRE_LO = 4;

    // Narrow timer control fields
    localparam int NT_PRE_LO  = 0;
    localparam int NT_ON      = 2;
    localparam int NT_POST_LO = 3;

    // Capture/compare control fields
    localparam int CC_MODE_LO = 2;
    localparam int CC_MOD_LO  = 0;
    localparam int CC_DUTY_LO = 4;

    // Oscillator divided by four
    localparam logic [1:0] OSC_DIV_LAST = 2'h3;

    // Prescaler terminal counts (divisor minus one)
    localparam logic [2:0] WPRE_MAX1  = 3'h0;
    localparam logic [2:0] WPRE_MAX2  = 3'h1;
    localparam logic [2:0] WPRE_MAX4  = 3'h3;
    localparam logic [2:0] WPRE_MAX8  = 3'h7;
    localparam logic [3:0] NPRE_MAX1  = 4'h0;
    localparam logic [3:0] NPRE_MAX4  = 4'h3;
    localparam logic [3:0] NPRE_MAX16 = 4'hf;
    localparam logic [15:0] WIDE_ALL_ONES = 16'hffff;

    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [3:0] {
        CCM_OFF     = 4'b0001,
        CCM_CAPTURE = 4'b0010,
        CCM_COMPARE = 4'b0100,
        CCM_PWM     = 4'b1000
    } tcp_ccp_mode_type;

endpackage

// >>> verilog/tcp_timer_block.sv
`timescale 1ns/100ps
module tcp_timer_block
    import tcp_pkg::*;
(
    // Clock and reset
    input  logic        aclk,
    input  logic        aresetn,
    // AXI4-Lite write address and data
    input  logic [7:0]  s_axi_awaddr,
    input  logic        s_axi_awvalid,
    output logic        s_axi_awready,
    input  logic [31:0] s_axi_wdata,
    input  logic [3:0]  s_axi_wstrb,
    input  logic        s_axi_wvalid,
    output logic        s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]  s_axi_bresp,
    output logic        s_axi_bvalid,
    input  logic        s_axi_bready,
    // AXI4-Lite read
    input  logic [7:0]  s_axi_araddr,
    input  logic        s_axi_arvalid,
    output logic        s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0]  s_axi_rresp,
    output logic        s_axi_rvalid,
    input  logic        s_axi_rready,
    // Event sources
    input  logic [7:0]  data_port,
    input  logic        free_running_counter_ovf,
    input  logic        serial_port_event,
    input  logic        external_clock_pin,
    // Capture/compare unit pin
    input  logic        ccp_pin_in,
    output logic        ccp_pin_out,
    output logic        ccp_pin_oe,
    // Interrupt requests
    output logic        peripheral_irq,
    output logic        processor_irq
);

    logic        awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
    logic        aw_have_ff, w_have_ff;
    logic [1:0]  bresp_ff, rresp_ff;
    logic [7:0]  awaddr_ff;
    logic [31:0] wdata_ff, rdata_ff;
    logic [3:0]  wstrb_ff;
    logic [7:0]  int_ctrl_ff, flags_ff, mask_ff, wide_ctrl_ff;
    logic [7:0]  nar_ctrl_ff, nar_count_ff, nar_period_ff, ccp_ctrl_ff;
    logic [15:0] wide_count_ff, ccp_data_ff;
    logic [7:0]  port_prev_ff;
    logic [1:0]  osc_div_ff;
    logic        ext_meta_ff, ext_sync_ff, ext_prev_ff;
    logic [2:0]  wide_pre_ff;
    logic [3:0]  nar_pre_ff, nar_post_ff;
    logic        cap_prev_ff, cmp_eq_ff;
    logic        pin_out_ff, pin_oe_ff, periph_irq_ff, proc_irq_ff;
    tcp_ccp_mode_type ccp_mode;

    // Bus handshake decode
    wire aw_take = s_axi_awvalid & awready_ff;
    wire w_take  = s_axi_wvalid & wready_ff;
    wire ar_take = s_axi_arvalid & arready_ff;
    wire wr_fire = aw_have_ff & w_have_ff & ~bvalid_ff;
    wire lane0   = wstrb_ff[0];
    wire lane1   = wstrb_ff[1];
    wire [7:0] wd_lo = wdata_ff[7:0];
    wire [7:0] wd_hi = wdata_ff[15:8];
    wire nxt_aw_have = (aw_have_ff | aw_take) & ~wr_fire;
    wire nxt_w_have  = (w_have_ff | w_take) & ~wr_fire;
    wire nxt_rvalid  = (rvalid_ff & ~s_axi_rready) | ar_take;

    wire wr_ic   = wr_fire & lane0 & (awaddr_ff == OFS_INT_CTRL);
    wire wr_fl   = wr_fire & lane0 & (awaddr_ff == OFS_PER_FLAGS);
    wire wr_mk   = wr_fire & lane0 & (awaddr_ff == OFS_PER_MASK);
    wire wr_wc   = wr_fire & lane0 & (awaddr_ff == OFS_WIDE_CTRL);
    wire sel_wn  = wr_fire & (awaddr_ff == OFS_WIDE_COUNT);
    wire wr_nc   = wr_fire & lane0 & (awaddr_ff == OFS_NARROW_CTRL);
    wire wr_nn   = wr_fire & lane0 & (awaddr_ff == OFS_NARROW_COUNT);
    wire wr_np   = wr_fire & lane0 & (awaddr_ff == OFS_NARROW_PER);
    wire wr_cc   = wr_fire & lane0 & (awaddr_ff == OFS_CCP_CTRL);
    wire sel_cd  = wr_fire & (awaddr_ff == OFS_CCP_DATA);
    wire wr_wn   = sel_wn & (lane0 | lane1);
    wire wr_cd   = sel_cd & (lane0 | lane1);
    wire wr_map  = (awaddr_ff == OFS_INT_CTRL) | (awaddr_ff == OFS_PER_FLAGS)
                 | (awaddr_ff == OFS_PER_MASK) | (awaddr_ff == OFS_WIDE_CTRL)
                 | (awaddr_ff == OFS_WIDE_COUNT) | (awaddr_ff == OFS_NARROW_CTRL)
                 | (awaddr_ff == OFS_NARROW_COUNT) | (awaddr_ff == OFS_NARROW_PER)
                 | (awaddr_ff == OFS_CCP_CTRL) | (awaddr_ff == OFS_CCP_DATA);

    // Read decode
    wire [15:0] rd_val =
        (s_axi_araddr == OFS_INT_CTRL)     ? {8'h00, int_ctrl_ff}   :
        (s_axi_araddr == OFS_PER_FLAGS)    ? {8'h00, flags_ff}      :
        (s_axi_araddr == OFS_PER_MASK)     ? {8'h00, mask_ff}       :
        (s_axi_araddr == OFS_WIDE_CTRL)    ? {8'h00, wide_ctrl_ff}  :
        (s_axi_araddr == OFS_WIDE_COUNT)   ? wide_count_ff          :
        (s_axi_araddr == OFS_NARROW_CTRL)  ? {8'h00, nar_ctrl_ff}   :
        (s_axi_araddr == OFS_NARROW_COUNT) ? {8'h00, nar_count_ff}  :
        (s_axi_araddr == OFS_NARROW_PER)   ? {8'h00, nar_period_ff} :
        (s_axi_araddr == OFS_CCP_CTRL)     ? {8'h00, ccp_ctrl_ff}   :
        (s_axi_araddr == OFS_CCP_DATA)     ? ccp_data_ff            : 16'h0000;
    wire rd_map = (s_axi_araddr == OFS_INT_CTRL) | (s_axi_araddr == OFS_PER_FLAGS)
                | (s_axi_araddr == OFS_PER_MASK) | (s_axi_araddr == OFS_WIDE_CTRL)
                | (s_axi_araddr == OFS_WIDE_COUNT) | (s_axi_araddr == OFS_NARROW_CTRL)
                | (s_axi_araddr == OFS_NARROW_COUNT) | (s_axi_araddr == OFS_NARROW_PER)
                | (s_axi_araddr == OFS_CCP_CTRL) | (s_axi_araddr == OFS_CCP_DATA);

    // Port events
    wire port_chg  = |(data_port[7:4] ^ port_prev_ff[7:4]);
    wire port_edge = data_port[0] ^ port_prev_ff[0];

    // Wide timer clocking
    wire quarter_tick = (osc_div_ff == OSC_DIV_LAST);
    wire ext_sel  = wide_ctrl_ff[WT_SYNC] ? ext_sync_ff : external_clock_pin;
    wire ext_rise = ext_sel & ~ext_prev_ff;
    wire src_tick = wide_ctrl_ff[WT_EXT] ? ext_rise : quarter_tick;
    wire [1:0] wpre_sel = wide_ctrl_ff[WT_PRE_LO +: 2];
    wire [2:0] wpre_max = (wpre_sel == 2'h3) ? WPRE_MAX8 :
                          (wpre_sel == 2'h2) ? WPRE_MAX4 :
                          (wpre_sel == 2'h1) ? WPRE_MAX2 : WPRE_MAX1;
    wire wide_on   = wide_ctrl_ff[WT_ON];
    wire wide_tick = wide_on & src_tick & (wide_pre_ff == wpre_max);
    wire [15:0] wide_wr_val = {lane1 ? wd_hi : wide_count_ff[15:8],
                               lane0 ? wd_lo : wide_count_ff[7:0]};
    wire wide_ovf  = wide_tick & (wide_count_ff == WIDE_ALL_ONES) & ~wr_wn;

    // Narrow timer
    wire [1:0] npre_sel = nar_ctrl_ff[NT_PRE_LO +: 2];
    wire [3:0] npre_max = npre_sel[1] ? NPRE_MAX16 :
                          npre_sel[0] ? NPRE_MAX4 : NPRE_MAX1;
    wire [3:0] post_max = nar_ctrl_ff[NT_POST_LO +: 4];
    wire nar_on    = nar_ctrl_ff[NT_ON];
    wire nar_inc   = nar_on & quarter_tick & (nar_pre_ff == npre_max);
    wire nar_match = nar_inc & (nar_count_ff == nar_period_ff) & ~wr_nn;
    wire nar_ovf   = nar_match & (nar_post_ff == post_max);

    // Capture/compare unit
    always_comb begin
        case (ccp_ctrl_ff[CC_MODE_LO +: 2])
            2'h1:    ccp_mode = CCM_CAPTURE;
            2'h2:    ccp_mode = CCM_COMPARE;
            2'h3:    ccp_mode = CCM_PWM;
            default: ccp_mode = CCM_OFF;
        endcase
    end
    wire [1:0] ccp_mod = ccp_ctrl_ff[CC_MOD_LO +: 2];
    // Modifier bit 0 picks the capture edge: set is rising, clear is falling
    wire cap_edge  = ccp_mod[0] ? (ccp_pin_in & ~cap_prev_ff) : (~ccp_pin_in & cap_prev_ff);
    wire cap_event = (ccp_mode == CCM_CAPTURE) & cap_edge;
    wire cmp_eq    = (wide_count_ff == ccp_data_ff);
    wire cmp_event = (ccp_mode == CCM_COMPARE) & cmp_eq & ~cmp_eq_ff;
    wire [15:0] ccp_wr_val = {lane1 ? wd_hi : ccp_data_ff[15:8],
                              lane0 ? wd_lo : ccp_data_ff[7:0]};
    // Exact 10-bit steps only with prescale 1; otherwise the two low bits
    // follow the oscillator quarter phase and resolution drops accordingly.
    wire [9:0] pwm_duty  = {ccp_data_ff[7:0], ccp_ctrl_ff[CC_DUTY_LO +: 2]};
    wire [9:0] pwm_phase = {nar_count_ff, osc_div_ff};
    wire pwm_level = (pwm_phase < pwm_duty);
    wire nxt_pin_out = (ccp_mode == CCM_PWM) ? pwm_level :
                       (cmp_event & ~ccp_mod[1]) ? ~ccp_mod[0] :
                       (ccp_mode == CCM_COMPARE) ? pin_out_ff : 1'b0;
    wire nxt_pin_oe  = (ccp_mode == CCM_PWM) | (ccp_mode == CCM_COMPARE);

    // Register next values; hardware sets win over a simultaneous clear
    wire [7:0] ic_set = {5'h00, free_running_counter_ovf, port_edge, port_chg};
    wire [7:0] pf_set = {4'h0, serial_port_event, cap_event | cmp_event,
                         nar_ovf, wide_ovf};
    wire [7:0] nxt_int_ctrl = (wr_ic ? (wd_lo & WMASK_INT_CTRL) : int_ctrl_ff) | ic_set;
    wire [7:0] nxt_flags = (wr_fl ? (wd_lo & WMASK_FLAGS) : flags_ff) | pf_set;
    wire [15:0] nxt_wide_count = wr_wn ? wide_wr_val :
                                 wide_tick ? wide_count_ff + 16'h0001 : wide_count_ff;
    wire [7:0] nxt_nar_count = wr_nn ? wd_lo :
                               nar_match ? RST_BYTE :
                               nar_inc ? nar_count_ff + 8'h01 : nar_count_ff;
    wire [15:0] nxt_ccp_data = wr_cd ? ccp_wr_val : cap_event ? wide_count_ff : ccp_data_ff;
    wire [2:0] nxt_wide_pre = (~wide_on | (src_tick & (wide_pre_ff == wpre_max))) ? 3'h0 :
                              src_tick ? wide_pre_ff + 3'h1 : wide_pre_ff;
    wire [3:0] nxt_nar_pre = (~nar_on | (quarter_tick & (nar_pre_ff == npre_max))) ? 4'h0 :
                             quarter_tick ? nar_pre_ff + 4'h1 : nar_pre_ff;
    wire [3:0] nxt_nar_post = ~nar_on ? 4'h0 : nar_ovf ? 4'h0 :
                              nar_match ? nar_post_ff + 4'h1 : nar_post_ff;
    wire core_req   = |(int_ctrl_ff[IC_FR_OVF:IC_PORT_CHG]
                        & int_ctrl_ff[IC_EN_LO +: 3]);
    wire periph_req = int_ctrl_ff[IC_PERIPH_EN] & |(flags_ff & mask_ff);

    // Bus slave
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_ff <= 1'b0;
            w_have_ff  <= 1'b0;
            awready_ff <= 1'b0;
            wready_ff  <= 1'b0;
            bvalid_ff  <= 1'b0;
            bresp_ff   <= RESP_OKAY;
        end else begin
            aw_have_ff <= nxt_aw_have;
            w_have_ff  <= nxt_w_have;
            awready_ff <= ~nxt_aw_have;
            wready_ff  <= ~nxt_w_have;
            bvalid_ff  <= wr_fire | (bvalid_ff & ~s_axi_bready);
            if (wr_fire) begin
                bresp_ff <= wr_map ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (aw_take) begin
            awaddr_ff <= s_axi_awaddr;
        end
        if (w_take) begin
            wdata_ff <= s_axi_wdata;
            wstrb_ff <= s_axi_wstrb;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_ff <= 1'b0;
            rvalid_ff  <= 1'b0;
            rdata_ff   <= 32'h0000_0000;
            rresp_ff   <= RESP_OKAY;
        end else begin
            arready_ff <= ~nxt_rvalid;
            rvalid_ff  <= nxt_rvalid;
            if (ar_take) begin
                rdata_ff <= {16'h0000, rd_val};
                rresp_ff <= rd_map ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    // Software registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            int_ctrl_ff   <= RST_BYTE;
            flags_ff      <= RST_BYTE;
            mask_ff       <= RST_BYTE;
            wide_ctrl_ff  <= RST_BYTE;
            nar_ctrl_ff   <= RST_BYTE;
            nar_period_ff <= RST_BYTE;
            ccp_ctrl_ff   <= RST_BYTE;
        end else begin
            int_ctrl_ff <= nxt_int_ctrl;
            flags_ff    <= nxt_flags;
            if (wr_mk) mask_ff <= wd_lo & WMASK_FLAGS;
            if (wr_wc) wide_ctrl_ff <= wd_lo & WMASK_WIDE_CTRL;
            if (wr_nc) nar_ctrl_ff <= wd_lo & WMASK_NAR_CTRL;
            if (wr_np) nar_period_ff <= wd_lo;
            if (wr_cc) ccp_ctrl_ff <= wd_lo & WMASK_CCP_CTRL;
        end
    end

    // Timers and event history
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wide_count_ff <= RST_WORD;
            nar_count_ff  <= RST_BYTE;
            ccp_data_ff   <= RST_WORD;
            wide_pre_ff   <= 3'h0;
            nar_pre_ff    <= 4'h0;
            nar_post_ff   <= 4'h0;
            osc_div_ff    <= 2'h0;
            port_prev_ff  <= RST_BYTE;
            ext_meta_ff   <= 1'b0;
            ext_sync_ff   <= 1'b0;
            ext_prev_ff   <= 1'b0;
            cap_prev_ff   <= 1'b0;
            cmp_eq_ff     <= 1'b0;
        end else begin
            wide_count_ff <= nxt_wide_count;
            nar_count_ff  <= nxt_nar_count;
            ccp_data_ff   <= nxt_ccp_data;
            wide_pre_ff   <= nxt_wide_pre;
            nar_pre_ff    <= nxt_nar_pre;
            nar_post_ff   <= nxt_nar_post;
            osc_div_ff    <= osc_div_ff + 2'h1;
            port_prev_ff  <= data_port;
            ext_meta_ff   <= external_clock_pin;
            ext_sync_ff   <= ext_meta_ff;
            ext_prev_ff   <= ext_sel;
            cap_prev_ff   <= ccp_pin_in;
            cmp_eq_ff     <= cmp_eq;
        end
    end

    // Pin and interrupt outputs
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_out_ff    <= 1'b0;
            pin_oe_ff     <= 1'b0;
            periph_irq_ff <= 1'b0;
            proc_irq_ff   <= 1'b0;
        end else begin
            pin_out_ff    <= nxt_pin_out;
            pin_oe_ff     <= nxt_pin_oe;
            periph_irq_ff <= periph_req;
            proc_irq_ff   <= core_req | periph_req;
        end
    end

    assign s_axi_awready = awready_ff;
    assign s_axi_wready  = wready_ff;
    assign s_axi_bvalid  = bvalid_ff;
    assign s_axi_bresp   = bresp_ff;
    assign s_axi_arready = arready_ff;
    assign s_axi_rvalid  = rvalid_ff;
    assign s_axi_rdata   = rdata_ff;
    assign s_axi_rresp   = rresp_ff;
    assign ccp_pin_out   = pin_out_ff;
    assign ccp_pin_oe    = pin_oe_ff;
    assign peripheral_irq = periph_irq_ff;
    assign processor_irq  = proc_irq_ff;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_wide_wrap_step;
        wide_tick && (wide_count_ff == WIDE_ALL_ONES) && !wr_wn;
    endsequence

    a_port_change_flag:  assert property (port_chg |=> int_ctrl_ff[IC_PORT_CHG])
        else $error("port change did not set its flag");
    a_port_edge_flag:    assert property (port_edge |=> int_ctrl_ff[IC_PORT_EDGE])
        else $error("port edge did not set its flag");
    a_counter_ovf_flag:  assert property (free_running_counter_ovf |=> int_ctrl_ff[IC_FR_OVF])
        else $error("counter overflow did not set its flag");
    a_periph_enable_gate: assert property (peripheral_irq |-> $past(int_ctrl_ff[IC_PERIPH_EN]))
        else $error("peripheral interrupt without enable");
    a_mask_gate_irq:     assert property (peripheral_irq |-> $past(|(flags_ff & mask_ff)))
        else $error("peripheral interrupt without masked flag");
    a_flag_stays_set:    assert property (flags_ff[PF_WIDE] && !wr_fl |=> flags_ff[PF_WIDE])
        else $error("wide flag dropped without software clear");
    a_wide_timer_hold:   assert property (!wide_on && !wr_wn |=> $stable(wide_count_ff))
        else $error("wide timer moved while off");
    a_wide_wrap_flag:    assert property (s_wide_wrap_step |=>
                                          wide_count_ff == RST_WORD && flags_ff[PF_WIDE])
        else $error("wide wrap not paired with flag");
    a_narrow_period_reset: assert property (nar_match |=> nar_count_ff == RST_BYTE)
        else $error("narrow count did not restart on period match");
    a_pwm_pin_drive:     assert property (ccp_mode == CCM_PWM |=> ccp_pin_oe)
        else $error("PWM mode not driving the pin");

endmodule // tcp_timer_block

// >>> dv/tcp_timer_block_test.sv
`timescale 1ns/100ps
module tcp_timer_block_test
    import tcp_pkg::*;
;
    logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic        s_axi_rready, free_running_counter_ovf, serial_port_event;
    logic        external_clock_pin, ccp_pin_in, ccp_pin_out, ccp_pin_oe;
    logic        peripheral_irq, processor_irq;
    logic [7:0]  s_axi_awaddr, s_axi_araddr, data_port;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd_val;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rd_resp;
    int          fail_count, total_checks;

    tcp_timer_block dut_u (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .data_port, .free_running_counter_ovf,
        .serial_port_event, .external_clock_pin, .ccp_pin_in, .ccp_pin_out, .ccp_pin_oe,
        .peripheral_irq, .processor_irq
    );

    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end

    task automatic chk_data(input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask

    task automatic chk_resp(input logic [1:0] exp, input logic [1:0] got);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask

    // Address and data are released separately, each at its own accepting edge.
    // Handshake outputs are looked at on the falling edge, where they are settled,
    // so the rising edge that updates them never races with the bench.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bit ad;
        bit wd;
        bit aw_ok;
        bit w_ok;
        ad = 0; wd = 0;
        @(posedge aclk);
        s_axi_awaddr <= a; s_axi_awvalid <= 1'b1; s_axi_wdata <= d; s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(negedge aclk);
            aw_ok = (s_axi_awready === 1'b1);
            w_ok = (s_axi_wready === 1'b1);
            @(posedge aclk);
            if (!ad && aw_ok) begin ad = 1; s_axi_awvalid <= 1'b0; end
            if (!wd && w_ok) begin wd = 1; s_axi_wvalid <= 1'b0; end
        end while (!(ad && wd));
        do begin
            @(negedge aclk);
            aw_ok = (s_axi_bvalid === 1'b1);
            rd_resp = s_axi_bresp;
            @(posedge aclk);
        end while (!aw_ok);
        s_axi_bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        bit ok;
        @(posedge aclk);
        s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
        do begin
            @(negedge aclk);
            ok = (s_axi_arready === 1'b1);
            @(posedge aclk);
        end while (!ok);
        s_axi_arvalid <= 1'b0;
        do begin
            @(negedge aclk);
            ok = (s_axi_rvalid === 1'b1);
            rd_val = s_axi_rdata; rd_resp = s_axi_rresp;
            @(posedge aclk);
        end while (!ok);
        s_axi_rready <= 1'b0;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        rd(a);
        chk_data(e, rd_val);
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Whole sequence needs about four hundred cycles; a hung handshake ends here
    initial begin
        #(20000 * 100);
        fail_count++;
        end_of_test();
    end

    initial begin
        fail_count = 0; total_checks = 0; aresetn = 1'b0; data_port = 8'h00;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        s_axi_awaddr = 8'h00; s_axi_araddr = 8'h00; s_axi_wdata = 32'h0; s_axi_wstrb = 4'hf;
        {free_running_counter_ovf, serial_port_event, external_clock_pin, ccp_pin_in} = 4'h0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rchk(OFS_WIDE_COUNT, 32'h0);
        wr(OFS_INT_CTRL, 32'hff); rchk(OFS_INT_CTRL, 32'h7f);
        wr(OFS_PER_FLAGS, 32'hff); rchk(OFS_PER_FLAGS, 32'h0f);
        wr(OFS_PER_FLAGS, 32'h0); wr(OFS_INT_CTRL, 32'h0);
        chk_resp(RESP_OKAY, rd_resp);
        wr(OFS_WIDE_COUNT, 32'h1234); repeat (20) @(posedge aclk);
        rchk(OFS_WIDE_COUNT, 32'h1234);
        wr(OFS_NARROW_PER, 32'h5a); rchk(OFS_NARROW_PER, 32'h5a);
        wr(OFS_NARROW_COUNT, 32'ha5); rchk(OFS_NARROW_COUNT, 32'ha5);
        wr(OFS_NARROW_CTRL, 32'h7b); rchk(OFS_NARROW_CTRL, 32'h7b);
        wr(OFS_CCP_CTRL, 32'hff); rchk(OFS_CCP_CTRL, 32'h3f);
        wr(OFS_CCP_CTRL, 32'h0);
        rd(8'h40); chk_resp(RESP_SLVERR, rd_resp);
        wr(8'h40, 32'h1); chk_resp(RESP_SLVERR, rd_resp);
        $display("test registers done");
        data_port <= 8'h10; repeat (3) @(posedge aclk);
        rchk(OFS_INT_CTRL, 32'h01);
        data_port <= 8'h11; repeat (3) @(posedge aclk);
        rchk(OFS_INT_CTRL, 32'h03);
        free_running_counter_ovf <= 1'b1; @(posedge aclk); free_running_counter_ovf <= 1'b0;
        repeat (2) @(posedge aclk);
        rchk(OFS_INT_CTRL, 32'h07);
        wr(OFS_INT_CTRL, 32'h09); repeat (3) @(posedge aclk);
        chk_data(32'h1, {31'h0, processor_irq});
        wr(OFS_INT_CTRL, 32'h01); repeat (3) @(posedge aclk);
        chk_data(32'h0, {31'h0, processor_irq});
        serial_port_event <= 1'b1; @(posedge aclk); serial_port_event <= 1'b0;
        repeat (2) @(posedge aclk);
        rchk(OFS_PER_FLAGS, 32'h08);
        wr(OFS_PER_MASK, 32'h08); repeat (3) @(posedge aclk);
        chk_data(32'h0, {31'h0, peripheral_irq});
        wr(OFS_INT_CTRL, 32'h40); repeat (3) @(posedge aclk);
        chk_data(32'h3, {30'h0, peripheral_irq, processor_irq});
        wr(OFS_PER_MASK, 32'h0); repeat (3) @(posedge aclk);
        chk_data(32'h0, {31'h0, peripheral_irq});
        wr(OFS_INT_CTRL, 32'h0); wr(OFS_PER_FLAGS, 32'h0);
        rchk(OFS_PER_FLAGS, 32'h0);
        $display("test events done");
        wr(OFS_WIDE_COUNT, 32'hfffe); wr(OFS_WIDE_CTRL, 32'h01);
        repeat (12) @(posedge aclk);
        wr(OFS_WIDE_CTRL, 32'h0);
        rchk(OFS_PER_FLAGS, 32'h01);
        wr(OFS_WIDE_COUNT, 32'h0); wr(OFS_WIDE_CTRL, 32'h17);
        repeat (4) begin
            external_clock_pin <= 1'b1; repeat (4) @(posedge aclk);
            external_clock_pin <= 1'b0; repeat (4) @(posedge aclk);
        end
        rchk(OFS_WIDE_COUNT, 32'h2);
        wr(OFS_WIDE_CTRL, 32'h0);
        $display("test wide timer done");
        wr(OFS_NARROW_COUNT, 32'h0); wr(OFS_NARROW_PER, 32'h1); wr(OFS_PER_FLAGS, 32'h0);
        wr(OFS_NARROW_CTRL, 32'h0c); repeat (20) @(posedge aclk);
        wr(OFS_NARROW_CTRL, 32'h0);
        rchk(OFS_PER_FLAGS, 32'h02);
        $display("test narrow timer done");
        wr(OFS_WIDE_COUNT, 32'h100); wr(OFS_PER_FLAGS, 32'h0); wr(OFS_CCP_CTRL, 32'h05);
        ccp_pin_in <= 1'b1; repeat (3) @(posedge aclk);
        rchk(OFS_CCP_DATA, 32'h100);
        rchk(OFS_PER_FLAGS, 32'h04);
        wr(OFS_PER_FLAGS, 32'h0); wr(OFS_CCP_DATA, 32'h105); wr(OFS_CCP_CTRL, 32'h08);
        wr(OFS_WIDE_CTRL, 32'h01); repeat (40) @(posedge aclk);
        wr(OFS_WIDE_CTRL, 32'h0);
        rchk(OFS_PER_FLAGS, 32'h04);
        chk_data(32'h3, {30'h0, ccp_pin_oe, ccp_pin_out});
        wr(OFS_CCP_DATA, 32'hff); wr(OFS_CCP_CTRL, 32'h3c); repeat (3) @(posedge aclk);
        chk_data(32'h3, {30'h0, ccp_pin_oe, ccp_pin_out});
        wr(OFS_CCP_DATA, 32'h0); wr(OFS_CCP_CTRL, 32'h0c); repeat (3) @(posedge aclk);
        chk_data(32'h2, {30'h0, ccp_pin_oe, ccp_pin_out});
        $display("test capture compare pwm done");
        end_of_test();
    end
endmodule // tcp_timer_block_test
